// ==== rtl/pjd_pkg.sv ====
// Shared constants and types for the paper path jam detector.
package pjd_pkg;

  // ----------------------------------------------------------------
  // Timer slots
  // ----------------------------------------------------------------
  localparam int NUM_TIMERS = 14;
  localparam int T_T5_T3 = 0;
  localparam int T_T5_T4 = 1;
  localparam int T_T6_T3 = 2;
  localparam int T_T6_T5 = 3;
  localparam int T_T4_T3 = 4;
  localparam int T_T5_HOLD = 5;
  localparam int T_PICK_REG = 6;
  localparam int T_PICK_FEED = 7;
  localparam int T_T3_REG = 8;
  localparam int T_SWB_REG = 9;
  localparam int T_SWB_STALL = 10;
  localparam int T_DUP_FUS = 11;
  localparam int T_FUS_MAX = 12;
  localparam int T_FUS_MIN = 13;

  // ----------------------------------------------------------------
  // Sheet length limits in millimetres
  // ----------------------------------------------------------------
  localparam logic [11:0] UNIV_MAX_MM = 12'd470;
  localparam logic [11:0] OVERLEN_MM = 12'd40;

  // ----------------------------------------------------------------
  // Event code fields
  // ----------------------------------------------------------------
  localparam logic [7:0] JAM_CLASS = 8'h13;
  localparam logic [3:0] Z_DUPLEX = 4'hd;
  localparam logic [23:0] CODE_RESET = 24'h000000;

  typedef enum logic [3:0] {
    PJD_FM_PHOTO = 4'h0,
    PJD_FM_NORMAL_AUTO = 4'h1,
    PJD_FM_NORMAL_TYPED = 4'h2,
    PJD_FM_LIGHT = 4'h3,
    PJD_FM_HEAVY1 = 4'h4,
    PJD_FM_HEAVY2 = 4'h5,
    PJD_FM_HEAVY3 = 4'h6,
    PJD_FM_GLOSSY1 = 4'h7,
    PJD_FM_GLOSSY2 = 4'h8,
    PJD_FM_GLOSSY3 = 4'h9,
    PJD_FM_GLOSS_FILM = 4'ha,
    PJD_FM_TRANSPARENCY = 4'hb,
    PJD_FM_LABEL = 4'hc,
    PJD_FM_ENVELOPE = 4'hd,
    PJD_FM_ROUGH = 4'he
  } pjd_fuser_mode_e;

endpackage

// ==== rtl/pjd_timer_if.sv ====
// Start, stop and expiry signals between the detector and one sheet timer.
`timescale 1ns/1ps
interface pjd_timer_if #(parameter int CW = 24);
  logic start;
  logic stop;
  logic [CW-1:0] limit;
  logic running;
  logic expired;

  modport timer (input start, input stop, input limit, output running, output expired);
  modport ctrl (output start, output stop, output limit, input running, input expired);
endinterface

// ==== rtl/pjd_timer.sv ====
// One per-sheet timeout timer.
`timescale 1ns/1ps
module pjd_timer #(
  parameter int CW = 24
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Control
  pjd_timer_if.timer tif
);

  logic [CW-1:0] cnt_reg;
  logic running_reg;
  logic expired_reg;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  // A limit of zero behaves as one cycle so a timer can never hang.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
      running_reg <= 1'b0;
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= 1'b0;
      if (tif.start) begin
        cnt_reg <= '0;
        running_reg <= 1'b1;
      end else if (tif.stop) begin
        running_reg <= 1'b0;
      end else if (running_reg) begin
        if (cnt_reg + CW'(1) >= tif.limit) begin
          running_reg <= 1'b0;
          expired_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + CW'(1);
        end
      end
    end
  end

  assign tif.running = running_reg;
  assign tif.expired = expired_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  stop_halts_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    tif.stop && !tif.start |=> !tif.running && !tif.expired)
    else $error("timer kept running after stop");
  start_arms_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    tif.start |=> tif.running && !tif.expired)
    else $error("timer not armed by start");

endmodule

// ==== rtl/pjd_top.sv ====
// Paper path jam detector: sheet timers, length check and event latch.
`timescale 1ns/1ps
module pjd_top #(
  parameter int CW = 24,
  parameter logic [11:0] LEDGER_LEN_MM = 12'd432
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Paper sensors, high while paper is present
  input wire logic upper_tray_feed_sensor_i,
  input wire logic tray4_feed_sensor_i,
  input wire logic fifth_tray_feed_sensor_i,
  input wire logic sixth_tray_feed_sensor_i,
  input wire logic reg_sensor_i,
  input wire logic fuser_out_sensor_i,
  // Engine sequencer
  input wire logic pickup_start_i,
  input wire logic [3:0] pickup_tray_i,
  input wire logic duplex_i,
  input wire logic switchback_arrive_i,
  input wire logic switchback_reverse_i,
  input wire logic [3:0] fuser_mode_i,
  input wire logic len_valid_i,
  input wire logic [11:0] sheet_len_mm_i,
  input wire logic custom_len_en_i,
  input wire logic [11:0] custom_len_mm_i,
  // Limits in clock cycles, one per timer slot
  input wire logic [pjd_pkg::NUM_TIMERS-1:0][CW-1:0] limit_i,
  // Formatter side
  input wire logic event_ack_i,
  output logic event_valid_o,
  output logic [23:0] event_code_o,
  output logic event_overrun_o
);

  localparam int NT = pjd_pkg::NUM_TIMERS;
  localparam logic [23:0] CODE_ZERO = pjd_pkg::CODE_RESET;

  function automatic logic [23:0] jam_code(input logic [3:0] w, input logic [3:0] x,
                                           input logic [3:0] y, input logic [3:0] z);
    jam_code = {pjd_pkg::JAM_CLASS, w, x, y, z};
  endfunction

  // ----------------------------------------------------------------
  // Sensor edges and sheet context
  // ----------------------------------------------------------------
  logic [5:0] sens;
  logic [5:0] sens_prev_reg;
  logic [5:0] rise;
  logic [5:0] fall;
  logic [3:0] tray_reg;
  logic [3:0] fmode;

  assign sens = {fuser_out_sensor_i, reg_sensor_i, sixth_tray_feed_sensor_i,
                 fifth_tray_feed_sensor_i, tray4_feed_sensor_i, upper_tray_feed_sensor_i};
  assign rise = sens & ~sens_prev_reg;
  assign fall = ~sens & sens_prev_reg;
  assign fmode = fuser_mode_i;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sens_prev_reg <= 6'h00;
    end else begin
      sens_prev_reg <= sens;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tray_reg <= 4'h0;
    end else if (pickup_start_i) begin
      tray_reg <= pickup_tray_i;
    end
  end

  // ----------------------------------------------------------------
  // Timer starts and stops
  // ----------------------------------------------------------------
  logic [NT-1:0] t_start;
  logic [NT-1:0] t_stop;
  logic [NT-1:0] t_run;
  logic [NT-1:0] t_exp;
  logic up_tray;

  assign up_tray = (tray_reg >= 4'h3) && (tray_reg <= 4'h6);

  always_comb begin
    t_start = '0;
    t_stop = '0;
    t_start[pjd_pkg::T_T5_T3] = rise[2];
    t_stop[pjd_pkg::T_T5_T3] = rise[0];
    t_start[pjd_pkg::T_T5_T4] = rise[2];
    t_stop[pjd_pkg::T_T5_T4] = rise[1];
    t_start[pjd_pkg::T_T6_T3] = rise[3];
    t_stop[pjd_pkg::T_T6_T3] = rise[0];
    t_start[pjd_pkg::T_T6_T5] = rise[3];
    t_stop[pjd_pkg::T_T6_T5] = rise[2];
    t_start[pjd_pkg::T_T4_T3] = rise[1];
    t_stop[pjd_pkg::T_T4_T3] = rise[0];
    t_start[pjd_pkg::T_T5_HOLD] = rise[2];
    t_stop[pjd_pkg::T_T5_HOLD] = fall[2];
    t_start[pjd_pkg::T_PICK_REG] = pickup_start_i && (pickup_tray_i == 4'h1 ||
                                                      pickup_tray_i == 4'h2);
    t_stop[pjd_pkg::T_PICK_REG] = rise[4];
    t_start[pjd_pkg::T_PICK_FEED] = pickup_start_i && (pickup_tray_i == 4'h3 ||
                                                       pickup_tray_i == 4'h6);
    t_stop[pjd_pkg::T_PICK_FEED] = (tray_reg == 4'h6) ? rise[3] : rise[0];
    t_start[pjd_pkg::T_T3_REG] = rise[0] && up_tray && !duplex_i;
    t_stop[pjd_pkg::T_T3_REG] = rise[4];
    t_start[pjd_pkg::T_SWB_REG] = switchback_reverse_i;
    t_stop[pjd_pkg::T_SWB_REG] = rise[4];
    t_start[pjd_pkg::T_SWB_STALL] = switchback_arrive_i;
    t_stop[pjd_pkg::T_SWB_STALL] = switchback_reverse_i;
    t_start[pjd_pkg::T_DUP_FUS] = rise[4] && duplex_i;
    t_stop[pjd_pkg::T_DUP_FUS] = rise[5];
    t_start[pjd_pkg::T_FUS_MAX] = rise[5];
    t_stop[pjd_pkg::T_FUS_MAX] = fall[5];
    t_start[pjd_pkg::T_FUS_MIN] = rise[5];
    t_stop[pjd_pkg::T_FUS_MIN] = fall[5];
  end

  generate
    for (genvar i = 0; i < NT; i++) begin : g_tmr
      pjd_timer_if #(.CW(CW)) tif ();
      assign tif.start = t_start[i];
      assign tif.stop = t_stop[i];
      assign tif.limit = limit_i[i];
      assign t_run[i] = tif.running;
      assign t_exp[i] = tif.expired;
      pjd_timer #(.CW(CW)) u_tmr (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .tif(tif)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Jam sources and their codes
  // ----------------------------------------------------------------
  logic wrap_hit;
  logic len_hit;
  logic [11:0] t1_base;
  logic [12:0] len_limit;
  logic [23:0] tcode [NT];

  assign wrap_hit = fall[5] && t_run[pjd_pkg::T_FUS_MIN];
  assign t1_base = (custom_len_en_i && custom_len_mm_i > pjd_pkg::UNIV_MAX_MM) ?
                   custom_len_mm_i : pjd_pkg::UNIV_MAX_MM;
  assign len_limit = (tray_reg == 4'h1) ? {1'b0, t1_base} + {1'b0, pjd_pkg::OVERLEN_MM} :
                     {1'b0, LEDGER_LEN_MM} + {1'b0, pjd_pkg::OVERLEN_MM};
  assign len_hit = len_valid_i && (tray_reg >= 4'h1) && (tray_reg <= 4'h6) &&
                   ({1'b0, sheet_len_mm_i} >= len_limit);

  always_comb begin
    tcode[pjd_pkg::T_T5_T3] = jam_code(4'ha, 4'h3, 4'hd, 4'h5);
    tcode[pjd_pkg::T_T5_T4] = jam_code(4'ha, 4'h4, 4'hd, 4'h5);
    tcode[pjd_pkg::T_T6_T3] = jam_code(4'ha, 4'h3, 4'hd, 4'h6);
    tcode[pjd_pkg::T_T6_T5] = jam_code(4'ha, 4'h5, 4'hd, 4'h6);
    tcode[pjd_pkg::T_T4_T3] = (tray_reg == 4'h5) ? jam_code(4'ha, 4'h5, 4'hd, 4'h5)
                                                 : jam_code(4'ha, 4'h3, 4'hd, 4'h4);
    tcode[pjd_pkg::T_T5_HOLD] = jam_code(4'ha, 4'h5, 4'ha, 4'h5);
    tcode[pjd_pkg::T_PICK_REG] = jam_code(4'hb, 4'h2, 4'hd, tray_reg);
    tcode[pjd_pkg::T_PICK_FEED] = jam_code(4'ha, tray_reg, 4'hd, tray_reg);
    tcode[pjd_pkg::T_T3_REG] = jam_code(4'hb, 4'h2, 4'hd, tray_reg);
    tcode[pjd_pkg::T_SWB_REG] = jam_code(4'hb, 4'h2, 4'hd, pjd_pkg::Z_DUPLEX);
    tcode[pjd_pkg::T_SWB_STALL] = jam_code(4'hb, 4'h2, 4'h9, tray_reg);
    tcode[pjd_pkg::T_DUP_FUS] = jam_code(4'hb, 4'h9, 4'hd, pjd_pkg::Z_DUPLEX);
    tcode[pjd_pkg::T_FUS_MAX] = jam_code(4'hb, 4'h9, 4'ha, fmode);
    tcode[pjd_pkg::T_FUS_MIN] = CODE_ZERO;
  end

  // Lowest slot wins; wrap and length checks come after the timers.
  logic hit;
  logic [23:0] hit_code;
  logic [NT-1:0] t_jam;

  assign t_jam = t_exp & ~(NT'(1) << pjd_pkg::T_FUS_MIN);

  always_comb begin
    hit = 1'b0;
    hit_code = CODE_ZERO;
    if (wrap_hit) begin
      hit = 1'b1;
      hit_code = jam_code(4'hb, 4'h9, 4'hc, fmode);
    end
    if (len_hit) begin
      hit = 1'b1;
      hit_code = jam_code(4'hb, 4'h2, 4'ha, tray_reg);
    end
    for (int i = NT - 1; i >= 0; i--) begin
      if (t_jam[i]) begin
        hit = 1'b1;
        hit_code = tcode[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Event latch
  // ----------------------------------------------------------------
  logic valid_reg;
  logic [23:0] code_reg;
  logic overrun_reg;

  // A new jam in the acknowledge cycle is loaded, so it is never lost.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      valid_reg <= 1'b0;
      code_reg <= CODE_ZERO;
    end else if (hit && (!valid_reg || event_ack_i)) begin
      valid_reg <= 1'b1;
      code_reg <= hit_code;
    end else if (event_ack_i) begin
      valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      overrun_reg <= 1'b0;
    end else if (hit && valid_reg && !event_ack_i) begin
      overrun_reg <= 1'b1;
    end else if (event_ack_i) begin
      overrun_reg <= 1'b0;
    end
  end

  assign event_valid_o = valid_reg;
  assign event_code_o = code_reg;
  assign event_overrun_o = overrun_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  flag_held_a: assert property (valid_reg && !event_ack_i |=> valid_reg && $stable(code_reg))
    else $error("event dropped before acknowledge");
  wrap_code_a: assert property (wrap_hit && !(|t_jam) && !len_hit && !valid_reg |=>
    code_reg == {8'h13, 8'hb9, 4'hc, $past(fuser_mode_i)})
    else $error("wrap jam code wrong");
  dwell_code_a: assert property (t_jam == (NT'(1) << pjd_pkg::T_FUS_MAX) && !valid_reg |=>
    code_reg[23:4] == 20'h13b9a && valid_reg)
    else $error("fuser dwell code wrong");
  swb_reg_a: assert property (t_jam == (NT'(1) << pjd_pkg::T_SWB_REG) && !valid_reg |=>
    code_reg == 24'h13b2dd)
    else $error("switchback late code wrong");
  dup_fus_a: assert property (t_jam == (NT'(1) << pjd_pkg::T_DUP_FUS) && !valid_reg |=>
    code_reg == 24'h13b9dd)
    else $error("duplex late to fuser code wrong");
  t5_t3_a: assert property (t_jam == 14'h0001 && !valid_reg |=> code_reg == 24'h13a3d5)
    else $error("tray5 to tray3 code wrong");
  t6_t5_a: assert property (t_jam == 14'h0008 && !valid_reg |=> code_reg == 24'h13a5d6)
    else $error("tray6 to tray5 code wrong");
  hold5_a: assert property (t_jam == 14'h0020 && !valid_reg |=> code_reg == 24'h13a5a5)
    else $error("tray5 hold code wrong");
  len_a: assert property (len_hit && !(|t_jam) && !valid_reg |=>
    code_reg[23:4] == 20'h13b2a && code_reg[3:0] == $past(tray_reg))
    else $error("over length code wrong");
  ack_set_wins_a: assert property (valid_reg && event_ack_i && hit |=> valid_reg)
    else $error("new jam lost at acknowledge");

  wrap_seen_c: cover property (wrap_hit ##1 valid_reg);
  dwell_seen_c: cover property (t_jam[pjd_pkg::T_FUS_MAX] ##1 valid_reg);
  ack_seen_c: cover property (valid_reg ##1 event_ack_i ##1 !valid_reg);
  overrun_seen_c: cover property (overrun_reg);

endmodule

// ==== dv/pjd_engine_model.sv ====
// Engine sequencer and paper sensor model that feeds the jam detector.
`timescale 1ns/1ps
module pjd_engine_model (
  // Clock
  input wire logic core_clk_i,
  // Sensors: fuser, registration, tray 6, tray 5, tray 4, tray 3
  output logic [5:0] sensor_o,
  // Sequencer
  output logic pickup_start_o,
  output logic [3:0] pickup_tray_o,
  output logic duplex_o,
  output logic sb_arrive_o,
  output logic sb_reverse_o,
  output logic [3:0] fuser_mode_o,
  output logic len_valid_o,
  output logic [11:0] sheet_len_mm_o,
  output logic custom_len_en_o,
  output logic [11:0] custom_len_mm_o
);
  initial begin
    {sensor_o, pickup_start_o, pickup_tray_o, duplex_o, sb_arrive_o} = '0;
    {sb_reverse_o, fuser_mode_o, len_valid_o, sheet_len_mm_o} = '0;
    {custom_len_en_o, custom_len_mm_o} = '0;
  end
  task automatic set_mode(input logic [3:0] m, input logic d, input logic c,
                        input logic [11:0] cl);
    @(negedge core_clk_i);
    sensor_o = '0;
    fuser_mode_o = m;
    duplex_o = d;
    custom_len_en_o = c;
    custom_len_mm_o = cl;
  endtask
  task automatic sense(input int k, input logic v);
    @(negedge core_clk_i);
    sensor_o[k] = v;
  endtask
  // Pulses last one cycle; the qualifying value is scrambled once it is no longer valid.
  task automatic pulse(input int k, input logic [11:0] arg);
    @(negedge core_clk_i);
    case (k)
      6: begin
        pickup_start_o = 1'b1;
        pickup_tray_o = arg[3:0];
      end
      7: sb_arrive_o = 1'b1;
      8: sb_reverse_o = 1'b1;
      default: begin
        len_valid_o = 1'b1;
        sheet_len_mm_o = arg;
      end
    endcase
    @(negedge core_clk_i);
    {pickup_start_o, sb_arrive_o, sb_reverse_o, len_valid_o} = '0;
    pickup_tray_o = ~pickup_tray_o;
    sheet_len_mm_o = ~sheet_len_mm_o;
  endtask
endmodule

// ==== dv/pjd_bench.sv ====
// Self-checking bench for the paper path jam detector.
`timescale 1ns/1ps
module pjd_bench;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic event_ack_i = 1'b0;
  logic [pjd_pkg::NUM_TIMERS-1:0][23:0] lim = '{default: 24'd500};
  logic [5:0] sen;
  logic pk, dup, sba, sbr, lv, cen;
  logic [3:0] ptray, fmode;
  logic [11:0] slen, clen;
  logic valid, ovr;
  logic [23:0] code;
  int mismatches = 0;
  int comparisons = 0;

  always #25 core_clk_i = ~core_clk_i;

  pjd_engine_model pjd_engine_model_i (.core_clk_i(core_clk_i), .sensor_o(sen),
    .pickup_start_o(pk), .pickup_tray_o(ptray), .duplex_o(dup), .sb_arrive_o(sba),
    .sb_reverse_o(sbr), .fuser_mode_o(fmode), .len_valid_o(lv), .sheet_len_mm_o(slen),
    .custom_len_en_o(cen), .custom_len_mm_o(clen));

  pjd_top pjd_top_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .upper_tray_feed_sensor_i(sen[0]), .tray4_feed_sensor_i(sen[1]),
    .fifth_tray_feed_sensor_i(sen[2]), .sixth_tray_feed_sensor_i(sen[3]),
    .reg_sensor_i(sen[4]), .fuser_out_sensor_i(sen[5]), .pickup_start_i(pk),
    .pickup_tray_i(ptray), .duplex_i(dup), .switchback_arrive_i(sba),
    .switchback_reverse_i(sbr), .fuser_mode_i(fmode), .len_valid_i(lv),
    .sheet_len_mm_i(slen), .custom_len_en_i(cen), .custom_len_mm_i(clen),
    .limit_i(lim), .event_ack_i(event_ack_i), .event_valid_o(valid),
    .event_code_o(code), .event_overrun_o(ovr));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset();
    @(negedge core_clk_i);
    srst_i = 1'b1;
    lim = '{default: 24'd500};
    // Sensors drop before release so that no stale edge starts a timer.
    pjd_engine_model_i.set_mode(4'h0, 1'b0, 1'b0, 12'h0);
    repeat (10) @(negedge core_clk_i);
    srst_i = 1'b0;
    chk("reset flags", 24'h0, {22'h0, valid, ovr});
    chk("reset code", 24'h0, code);
  endtask

  // The event must appear exactly lat edges on, and for lat above 1 not one edge earlier.
  task automatic expect_event(input int lat, input logic [23:0] exp);
    for (int i = 1; i <= lat; i++) begin
      @(negedge core_clk_i);
      if (i == lat - 1) chk("early valid", 24'h0, {23'h0, valid});
    end
    chk("valid", 24'h1, {23'h0, valid});
    chk("code", exp, code);
  endtask

  task automatic ack_event();
    event_ack_i = 1'b1;
    @(negedge core_clk_i);
    event_ack_i = 1'b0;
    chk("valid after ack", 24'h0, {23'h0, valid});
  endtask

  // Pickup from tray, then one stimulus that starts the timer in slot.
  task automatic timer_case(input int k, input int slot, input int l, input logic [3:0] tray,
                            input logic d, input logic [23:0] exp);
    do_reset();
    lim[slot] = l;
    if (slot == pjd_pkg::T_FUS_MAX) lim[pjd_pkg::T_FUS_MIN] = 24'd1;
    pjd_engine_model_i.set_mode(exp[3:0], d, 1'b0, 12'h0);
    pjd_engine_model_i.pulse(6, {8'h0, tray});
    if (k < 6) pjd_engine_model_i.sense(k, 1'b1);
    else pjd_engine_model_i.pulse(k, {8'h0, tray});
    expect_event((k < 6) ? l + 2 : l + 1, exp);
    ack_event();
  endtask

  task automatic len_case(input logic [3:0] tray, input logic c, input logic [11:0] cl,
                          input logic [11:0] len, input logic jam);
    do_reset();
    pjd_engine_model_i.set_mode(4'h0, 1'b0, c, cl);
    pjd_engine_model_i.pulse(6, {8'h0, tray});
    pjd_engine_model_i.pulse(9, len);
    if (jam) begin
      expect_event(1, {16'h13b2, 4'ha, tray});
      ack_event();
    end else begin
      @(negedge core_clk_i);
      chk("no length jam", 24'h0, {23'h0, valid});
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_tray_paths();
    timer_case(2, 0, 3, 4'h5, 1'b0, 24'h13a3d5);
    timer_case(2, 1, 4, 4'h5, 1'b0, 24'h13a4d5);
    timer_case(3, 2, 5, 4'h6, 1'b0, 24'h13a3d6);
    timer_case(3, 3, 2, 4'h6, 1'b0, 24'h13a5d6);
    timer_case(1, 4, 6, 4'h4, 1'b0, 24'h13a3d4);
    timer_case(1, 4, 3, 4'h5, 1'b0, 24'h13a5d5);
    timer_case(2, 5, 7, 4'h5, 1'b0, 24'h13a5a5);
    $display("test_tray_paths done");
  endtask

  task automatic test_pickup_and_reg();
    timer_case(6, 6, 5, 4'h1, 1'b0, 24'h13b2d1);
    timer_case(6, 6, 2, 4'h2, 1'b0, 24'h13b2d2);
    timer_case(6, 7, 4, 4'h3, 1'b0, 24'h13a3d3);
    timer_case(6, 7, 8, 4'h6, 1'b0, 24'h13a6d6);
    for (int t = 3; t <= 6; t++) begin
      timer_case(0, 8, t, 4'(t), 1'b0, {20'h13b2d, 4'(t)});
    end
    timer_case(8, 9, 6, 4'h1, 1'b1, 24'h13b2dd);
    timer_case(4, 11, 5, 4'h1, 1'b1, 24'h13b9dd);
    timer_case(7, 10, 4, 4'h4, 1'b1, 24'h13b294);
    $display("test_pickup_and_reg done");
  endtask

  task automatic test_fuser();
    for (int m = 0; m <= 14; m++) begin
      timer_case(5, 12, 4, 4'h1, 1'b0, {20'h13b9a, 4'(m)});
    end
    do_reset();
    lim[pjd_pkg::T_FUS_MIN] = 24'd10;
    pjd_engine_model_i.set_mode(4'h7, 1'b0, 1'b0, 12'h0);
    pjd_engine_model_i.sense(5, 1'b1);
    repeat (3) @(negedge core_clk_i);
    pjd_engine_model_i.sense(5, 1'b0);
    expect_event(1, 24'h13b9c7);
    ack_event();
    $display("test_fuser done");
  endtask

  task automatic test_length();
    len_case(4'h1, 1'b0, 12'd0, 12'd510, 1'b1);
    len_case(4'h1, 1'b0, 12'd0, 12'd509, 1'b0);
    len_case(4'h1, 1'b1, 12'd500, 12'd539, 1'b0);
    len_case(4'h1, 1'b1, 12'd500, 12'd540, 1'b1);
    len_case(4'h2, 1'b0, 12'd0, 12'd472, 1'b1);
    len_case(4'h6, 1'b0, 12'd0, 12'd471, 1'b0);
    $display("test_length done");
  endtask

  task automatic test_overrun();
    do_reset();
    lim[0] = 24'd3;
    lim[1] = 24'd6;
    pjd_engine_model_i.pulse(6, 12'h5);
    pjd_engine_model_i.sense(2, 1'b1);
    expect_event(5, 24'h13a3d5);
    repeat (4) @(negedge core_clk_i);
    chk("overrun", 24'h1, {23'h0, ovr});
    chk("held code", 24'h13a3d5, code);
    ack_event();
    chk("overrun after ack", 24'h0, {23'h0, ovr});
    @(negedge core_clk_i);
    ack_event();
    $display("test_overrun done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    test_tray_paths();
    test_pickup_and_reg();
    test_fuser();
    test_length();
    test_overrun();
    tally_and_finish();
  end
endmodule
